// ---- inc/rid_regs.svh ----
// constants for the 14-bit instruction decoder core
`ifndef RID_REGS_SVH
`define RID_REGS_SVH
`define RID_OSC_PER_CYCLE 4
`define RID_PHASE_ADDR 2'h0
`define RID_PHASE_LAST 2'h3
`define RID_PC_RESET 13'h0000
`define RID_NOP_WORD 14'h0000
`define RID_PORT_ADDR 7'h06
`define RID_TIMER_ADDR 7'h01
`define RID_TO_RESET 1'h1
`define RID_PD_RESET 1'h1
`define RID_FMT_BYTE 2'h0
`define RID_FMT_BIT 2'h1
`define RID_FMT_CTRL 2'h2
`define RID_FMT_LIT 2'h3
`define RID_OP_MISC 4'h0
`define RID_OP_CLR 4'h1
`define RID_OP_SUB 4'h2
`define RID_OP_DEC 4'h3
`define RID_OP_OR 4'h4
`define RID_OP_AND 4'h5
`define RID_OP_XOR 4'h6
`define RID_OP_ADD 4'h7
`define RID_OP_MOV 4'h8
`define RID_OP_COM 4'h9
`define RID_OP_INC 4'ha
`define RID_OP_DECSZ 4'hb
`define RID_OP_RRF 4'hc
`define RID_OP_RLF 4'hd
`define RID_OP_SWAP 4'he
`define RID_OP_INCSZ 4'hf
`define RID_LO_RETURN 7'h08
`define RID_LO_INTERRUPT_RETURN 7'h09
`define RID_LO_STANDBY 7'h63
`define RID_LO_WDCLR 7'h64
`define RID_BOP_CLR 2'h0
`define RID_BOP_SET 2'h1
`define RID_BOP_SKC 2'h2
`define RID_BOP_SKS 2'h3
`endif

// ---- inc/rid_pkg.sv ----
// types shared by the instruction decoder core
package rid_pkg;
	typedef enum logic {RID_RUN, RID_STANDBY} rid_state_t;
	typedef struct packed {
		logic carry;
		logic digit_carry;
		logic zero;
	} rid_flags_t;
	typedef struct packed {
		logic [6:0] addr;
		logic       we;
		logic [7:0] wdata;
	} rid_file_req_t;
endpackage

// ---- core/rid_core.sv ----
// 14-bit instruction decode and execute core
`default_nettype none
`include "rid_regs.svh"

module rid_core
	import rid_pkg::*;
#(
	parameter int STACK_DEPTH = 8
) (
	input  wire logic          ref_clk,
	input  wire logic          rst_n,
	input  wire logic [13:0]   prog_word,
	input  wire logic [7:0]    file_rd_data,
	input  wire logic [7:0]    port_pins,
	input  wire logic [4:0]    program_counter_high_latch,
	input  wire logic          prescaler_on_timer,
	input  wire logic          wake_req,
	output var  logic [12:0]   prog_addr_q,
	output var  rid_file_req_t file_req_q,
	output var  logic [7:0]    working_q,
	output var  rid_flags_t    flags_q,
	output var  logic          time_out_flag_q,
	output var  logic          power_down_flag_q,
	output var  logic          watchdog_clear_q,
	output var  logic          prescaler_clear_q,
	output var  logic          osc_stop_q,
	output var  logic          global_interrupt_enable_q
);
	localparam int PW = $clog2(STACK_DEPTH);

	// ----------------------------------------
	// state
	// ----------------------------------------
	rid_state_t    state_q, state_d;
	logic [1:0]    phase_q, phase_d;
	logic [13:0]   instr_q, instr_d;
	logic [12:0]   prog_addr_d;
	rid_file_req_t file_req_d;
	logic [7:0]    working_d;
	rid_flags_t    flags_d;
	logic          time_out_d, power_down_d;
	logic          watchdog_clear_d, prescaler_clear_d;
	logic          osc_stop_d, gie_d;
	logic [PW-1:0] ptr_q, ptr_d, ptr_dec;
	logic [12:0]   stack_q [STACK_DEPTH];
	logic [12:0]   stack_top;
	logic          push;
	logic [7:0]    pin_s1_q, pin_s2_q, pin_s3_q;
	logic [7:0]    pin_stable_q, pin_stable_d;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic        exec;
	logic [1:0]  fmt;
	logic [3:0]  op;
	logic        dbit;
	logic [6:0]  f_addr;
	logic [7:0]  lit;
	logic [2:0]  bidx;
	logic        is_misc, is_ret, is_interrupt_return, is_sleep, is_wdclr;
	logic [7:0]  opnd, res;
	logic [9:0]  sum;
	logic        store, wr_file, wr_w, skip, branch;

	assign exec      = (state_q == RID_RUN) && (phase_q == `RID_PHASE_LAST);
	assign fmt       = instr_q[13:12];
	assign op        = instr_q[11:8];
	assign dbit      = instr_q[7];
	assign f_addr    = instr_q[6:0];
	assign lit       = instr_q[7:0];
	assign bidx      = instr_q[9:7];
	assign is_misc   = (fmt == `RID_FMT_BYTE) && (op == `RID_OP_MISC) && !dbit;
	assign is_ret    = is_misc && (f_addr == `RID_LO_RETURN);
	assign is_interrupt_return = is_misc && (f_addr == `RID_LO_INTERRUPT_RETURN);
	assign is_sleep  = is_misc && (f_addr == `RID_LO_STANDBY);
	assign is_wdclr  = is_misc && (f_addr == `RID_LO_WDCLR);
	assign ptr_dec   = ptr_q - PW'(1);
	assign stack_top = stack_q[ptr_dec];
	// read-modify-write of the port sees the pins, not the latch
	assign opnd      = (f_addr == `RID_PORT_ADDR) ? pin_stable_q : file_rd_data;

	// carry out, digit carry, 8-bit sum
	function automatic logic [9:0] addc(input logic [7:0] a, input logic [7:0] b, input logic cin);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		return {s[8], h[4], s[7:0]};
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_d           = state_q;
		phase_d           = phase_q + 2'h1;
		instr_d           = instr_q;
		prog_addr_d       = prog_addr_q;
		file_req_d        = file_req_q;
		file_req_d.we     = 1'b0;
		working_d         = working_q;
		flags_d           = flags_q;
		time_out_d        = time_out_flag_q;
		power_down_d      = power_down_flag_q;
		watchdog_clear_d  = 1'b0;
		prescaler_clear_d = 1'b0;
		osc_stop_d        = osc_stop_q;
		gie_d             = global_interrupt_enable_q;
		ptr_d             = ptr_q;
		push              = 1'b0;
		res               = opnd;
		sum               = 10'h000;
		store             = 1'b0;
		wr_file           = 1'b0;
		wr_w              = 1'b0;
		skip              = 1'b0;
		branch            = 1'b0;
		pin_stable_d      = (pin_s2_q & pin_s3_q) | (pin_stable_q & (pin_s2_q | pin_s3_q));
		if (phase_q == `RID_PHASE_ADDR) begin
			file_req_d.addr = f_addr;
		end
		if (state_q == RID_STANDBY && wake_req) begin
			state_d    = RID_RUN;
			osc_stop_d = 1'b0;
		end
		if (exec) begin
			instr_d     = prog_word;
			prog_addr_d = prog_addr_q + 13'h0001;
			unique case (fmt)
				`RID_FMT_BYTE: begin
					store = 1'b1;
					unique case (op)
						`RID_OP_MISC: begin
							store = 1'b0;
							if (dbit) begin
								res     = working_q;
								wr_file = 1'b1;
							end else if (is_ret || is_interrupt_return) begin
								prog_addr_d = stack_top;
								ptr_d       = ptr_dec;
								branch      = 1'b1;
								if (is_interrupt_return) begin
									gie_d = 1'b1;
								end
							end else if (is_sleep) begin
								state_d          = RID_STANDBY;
								osc_stop_d       = 1'b1;
								power_down_d     = 1'b0;
								time_out_d       = 1'b1;
								watchdog_clear_d = 1'b1;
							end else if (is_wdclr) begin
								watchdog_clear_d = 1'b1;
								time_out_d       = 1'b1;
								power_down_d     = 1'b1;
							end
						end
						`RID_OP_CLR: begin
							res          = 8'h00;
							flags_d.zero = 1'b1;
						end
						`RID_OP_SUB: begin
							sum     = addc(opnd, ~working_q, 1'b1);
							res     = sum[7:0];
							flags_d = '{carry: sum[9], digit_carry: sum[8], zero: (sum[7:0] == 8'h00)};
						end
						`RID_OP_ADD: begin
							sum     = addc(opnd, working_q, 1'b0);
							res     = sum[7:0];
							flags_d = '{carry: sum[9], digit_carry: sum[8], zero: (sum[7:0] == 8'h00)};
						end
						`RID_OP_DEC, `RID_OP_DECSZ: res = opnd - 8'h01;
						`RID_OP_INC, `RID_OP_INCSZ: res = opnd + 8'h01;
						`RID_OP_OR:   res = opnd | working_q;
						`RID_OP_AND:  res = opnd & working_q;
						`RID_OP_XOR:  res = opnd ^ working_q;
						`RID_OP_MOV:  res = opnd;
						`RID_OP_COM:  res = ~opnd;
						`RID_OP_SWAP: res = {opnd[3:0], opnd[7:4]};
						`RID_OP_RLF: begin
							res           = {opnd[6:0], flags_q.carry};
							flags_d.carry = opnd[7];
						end
						`RID_OP_RRF: begin
							res           = {flags_q.carry, opnd[7:1]};
							flags_d.carry = opnd[0];
						end
					endcase
					if (op inside {`RID_OP_DEC, `RID_OP_INC, `RID_OP_OR, `RID_OP_AND,
					               `RID_OP_XOR, `RID_OP_MOV, `RID_OP_COM}) begin
						flags_d.zero = (res == 8'h00);
					end
					if (op inside {`RID_OP_DECSZ, `RID_OP_INCSZ}) begin
						skip = (res == 8'h00);
					end
					if (op == `RID_OP_CLR || op == `RID_OP_MISC) begin
						wr_file = wr_file || (store && dbit);
						wr_w    = store && !dbit;
					end else begin
						wr_file = dbit;
						wr_w    = !dbit;
					end
				end
				`RID_FMT_BIT: begin
					unique case (op[3:2])
						`RID_BOP_CLR: begin
							res     = opnd & ~(8'h01 << bidx);
							wr_file = 1'b1;
						end
						`RID_BOP_SET: begin
							res     = opnd | (8'h01 << bidx);
							wr_file = 1'b1;
						end
						`RID_BOP_SKC: skip = !opnd[bidx];
						`RID_BOP_SKS: skip = opnd[bidx];
					endcase
				end
				`RID_FMT_CTRL: begin
					branch      = 1'b1;
					push        = !op[3];
					prog_addr_d = {program_counter_high_latch[4:3], instr_q[10:0]};
					if (push) begin
						ptr_d = ptr_q + PW'(1);
					end
				end
				`RID_FMT_LIT: begin
					wr_w = 1'b1;
					unique casez (op)
						4'b00??: res = lit;
						4'b01??: begin
							res         = lit;
							prog_addr_d = stack_top;
							ptr_d       = ptr_dec;
							branch      = 1'b1;
						end
						4'b1000: begin
							res          = working_q | lit;
							flags_d.zero = (res == 8'h00);
						end
						4'b1001: begin
							res          = working_q & lit;
							flags_d.zero = (res == 8'h00);
						end
						4'b1010: begin
							res          = working_q ^ lit;
							flags_d.zero = (res == 8'h00);
						end
						4'b110?: begin
							sum     = addc(lit, ~working_q, 1'b1);
							res     = sum[7:0];
							flags_d = '{carry: sum[9], digit_carry: sum[8], zero: (sum[7:0] == 8'h00)};
						end
						4'b111?: begin
							sum     = addc(lit, working_q, 1'b0);
							res     = sum[7:0];
							flags_d = '{carry: sum[9], digit_carry: sum[8], zero: (sum[7:0] == 8'h00)};
						end
						default: wr_w = 1'b0;
					endcase
				end
			endcase
			if (wr_w) begin
				working_d = res;
			end
			if (wr_file) begin
				file_req_d.we    = 1'b1;
				file_req_d.wdata = res;
				// the timer write lands in the same cycle as the prescaler clear
				prescaler_clear_d = (f_addr == `RID_TIMER_ADDR) && prescaler_on_timer;
			end
			if (skip || branch) begin
				instr_d = `RID_NOP_WORD;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q                   <= RID_RUN;
			phase_q                   <= `RID_PHASE_ADDR;
			instr_q                   <= `RID_NOP_WORD;
			prog_addr_q               <= `RID_PC_RESET;
			file_req_q                <= '0;
			working_q                 <= 8'h00;
			flags_q                   <= '0;
			time_out_flag_q           <= `RID_TO_RESET;
			power_down_flag_q         <= `RID_PD_RESET;
			watchdog_clear_q          <= 1'b0;
			prescaler_clear_q         <= 1'b0;
			osc_stop_q                <= 1'b0;
			global_interrupt_enable_q <= 1'b0;
			ptr_q                     <= '0;
			pin_s1_q                  <= 8'h00;
			pin_s2_q                  <= 8'h00;
			pin_s3_q                  <= 8'h00;
			pin_stable_q              <= 8'h00;
		end else begin
			state_q                   <= state_d;
			phase_q                   <= phase_d;
			instr_q                   <= instr_d;
			prog_addr_q               <= prog_addr_d;
			file_req_q                <= file_req_d;
			working_q                 <= working_d;
			flags_q                   <= flags_d;
			time_out_flag_q           <= time_out_d;
			power_down_flag_q         <= power_down_d;
			watchdog_clear_q          <= watchdog_clear_d;
			prescaler_clear_q         <= prescaler_clear_d;
			osc_stop_q                <= osc_stop_d;
			global_interrupt_enable_q <= gie_d;
			ptr_q                     <= ptr_d;
			pin_s1_q                  <= port_pins;
			pin_s2_q                  <= pin_s1_q;
			pin_s3_q                  <= pin_s2_q;
			pin_stable_q              <= pin_stable_d;
		end
	end

	// a full stack wraps and overwrites its oldest entry
	for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				stack_q[i] <= `RID_PC_RESET;
			end else if (exec && push && ptr_q == PW'(i)) begin
				stack_q[i] <= prog_addr_q;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_phase_wrap;
		@(posedge ref_clk) disable iff (!rst_n)
		phase_q == `RID_PHASE_LAST |=> phase_q == `RID_PHASE_ADDR ##3 phase_q == `RID_PHASE_LAST;
	endproperty
	a_phase_wrap: assert property (p_phase_wrap) else $error("phase does not span four clocks");

	property p_one_cycle;
		@(posedge ref_clk) disable iff (!rst_n)
		exec && fmt == `RID_FMT_LIT && op[3:2] == 2'h0 |=> instr_q == $past(prog_word);
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("literal load lost prefetch");

	property p_dest_sel;
		@(posedge ref_clk) disable iff (!rst_n)
		exec && fmt == `RID_FMT_BYTE && op == `RID_OP_ADD |=> file_req_q.we == $past(dbit);
	endproperty
	a_dest_sel: assert property (p_dest_sel) else $error("destination bit ignored");

	property p_skip_zero;
		@(posedge ref_clk) disable iff (!rst_n)
		exec && fmt == `RID_FMT_BYTE && op == `RID_OP_DECSZ && opnd == 8'h01
		|=> instr_q == `RID_NOP_WORD && flags_q == $past(flags_q);
	endproperty
	a_skip_zero: assert property (p_skip_zero) else $error("decrement skip wrong");

	property p_jump;
		@(posedge ref_clk) disable iff (!rst_n)
		exec && fmt == `RID_FMT_CTRL
		|=> instr_q == `RID_NOP_WORD
		&& prog_addr_q == {$past(program_counter_high_latch[4:3]), $past(instr_q[10:0])};
	endproperty
	a_jump: assert property (p_jump) else $error("branch target wrong");

	property p_call_push;
		@(posedge ref_clk) disable iff (!rst_n)
		exec && fmt == `RID_FMT_CTRL && !op[3] |=> ptr_q == $past(ptr_q) + PW'(1);
	endproperty
	a_call_push: assert property (p_call_push) else $error("call did not push");

	property p_return_pop;
		@(posedge ref_clk) disable iff (!rst_n)
		exec && is_ret |=> prog_addr_q == $past(stack_top) && ptr_q == $past(ptr_dec);
	endproperty
	a_return_pop: assert property (p_return_pop) else $error("return did not pop");

	property p_wdclr;
		@(posedge ref_clk) disable iff (!rst_n)
		exec && is_wdclr |=> watchdog_clear_q && time_out_flag_q && power_down_flag_q ##1 !watchdog_clear_q;
	endproperty
	a_wdclr: assert property (p_wdclr) else $error("watchdog clear wrong");

	property p_standby;
		@(posedge ref_clk) disable iff (!rst_n)
		exec && is_sleep |=> osc_stop_q && !power_down_flag_q && time_out_flag_q && watchdog_clear_q;
	endproperty
	a_standby: assert property (p_standby) else $error("standby entry wrong");

	property p_timer_clear;
		@(posedge ref_clk) disable iff (!rst_n)
		file_req_q.we && file_req_q.addr == `RID_TIMER_ADDR && $past(prescaler_on_timer) |-> prescaler_clear_q;
	endproperty
	a_timer_clear: assert property (p_timer_clear) else $error("prescaler not cleared");
endmodule
`default_nettype wire

// ---- bench/rid_prog_mem.sv ----
// program memory model answering the core's fetch address
`default_nettype none
module rid_prog_mem (
	input  wire logic [12:0] addr,
	output var  logic [13:0] word
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [13:0] mem [64];

	// ----------------------------------------
	// read port
	// ----------------------------------------
	// only the low address bits are decoded, so every page aliases onto the
	// same words; jumps with high latch bits still land on real code
	always_comb word = mem[addr[5:0]];
endmodule
`default_nettype wire

// ---- bench/risc_14bit_instruction_decoder_bench.sv ----
// self-checking bench for the instruction decode core
`default_nettype none
module risc_14bit_instruction_decoder_bench
	import rid_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	logic          ref_clk, rst_n, prescaler_on_timer, wake_req;
	logic [4:0]    hl;
	logic [7:0]    port_pins, file_rd_data, working_q;
	logic [12:0]   prog_addr_q;
	logic [13:0]   prog_word;
	rid_file_req_t file_req_q;
	rid_flags_t    flags_q;
	logic          t_q, p_q, wdc_q, pclr_q, osc_stop_q, ie_q;
	logic [7:0]    fmem [128], mf [128], w, ed;
	logic [13:0]   prog [64], mi;
	logic [12:0]   stk [8], fa;
	logic [15:0]   seed;
	logic [6:0]    ea;
	logic          c, dcar, z, t_out, p_dn, ie, ewe, epc;
	int            sp, miscompares, cmp_count, wd_seen, wd_exp;

	rid_core rid_core_i (.ref_clk, .rst_n, .prog_word, .file_rd_data, .port_pins,
		.program_counter_high_latch(hl), .prescaler_on_timer, .wake_req, .prog_addr_q,
		.file_req_q, .working_q, .flags_q, .time_out_flag_q(t_q), .power_down_flag_q(p_q),
		.watchdog_clear_q(wdc_q), .prescaler_clear_q(pclr_q), .osc_stop_q,
		.global_interrupt_enable_q(ie_q));
	rid_prog_mem rid_prog_mem_i (.addr(prog_addr_q), .word(prog_word));

	assign file_rd_data = fmem[file_req_q.addr];

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) if (rst_n === 1'b1 && wdc_q === 1'b1) wd_seen++;

	// ----------------------------------------
	// checking and reference model
	// ----------------------------------------
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic test_done;
		if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic exec(input logic [13:0] i, output logic br, output logic [12:0] nfa);
		logic [7:0] a, r;
		logic [6:0] f;
		logic [3:0] op;
		logic       wr, uz, ar, dst, sb;
		op = i[11:8];
		f = i[6:0];
		a = i[13] ? i[7:0] : ((f == 7'h06) ? port_pins : mf[f]);
		r = w;
		{br, wr, uz, ar, dst} = 5'h0;
		nfa = fa + 13'h1;
		sb = i[13] ? !op[1] : (op == 4'h2);
		case (i[13:12])
			2'h0: begin
				dst = (op != 4'h0);
				uz = (op < 4'hb) && (op != 4'h0);
				ar = (op == 4'h2) || (op == 4'h7);
				case (op)
					4'h0: begin
						wr = i[7];
						if (!i[7] && f[6:1] == 6'h04) begin
							sp = (sp + 7) % 8;
							nfa = stk[sp];
							br = 1'b1;
							ie = ie | f[0];
						end
						if (!i[7] && f == 7'h64) begin
							{t_out, p_dn} = 2'h3;
							wd_exp++;
						end
						if (!i[7] && f == 7'h63) {t_out, p_dn} = 2'h2;
					end
					4'h1: r = 8'h0;
					4'h3, 4'hb: r = a - 8'h1;
					4'h4: r = a | w;
					4'h5: r = a & w;
					4'h6: r = a ^ w;
					4'h8: r = a;
					4'h9: r = ~a;
					4'ha, 4'hf: r = a + 8'h1;
					4'hc: {r, c} = {c, a};
					4'hd: {c, r} = {a, c};
					4'he: r = {a[3:0], a[7:4]};
					default: ;
				endcase
				br = br | ((op == 4'hb || op == 4'hf) && r == 8'h0);
			end
			2'h1: begin
				r = a;
				r[i[9:7]] = i[10];
				wr = !i[11];
				br = i[11] && (a[i[9:7]] == i[10]);
			end
			2'h2: begin
				if (!i[11]) begin
					stk[sp] = fa;
					sp = (sp + 1) % 8;
				end
				nfa = {hl[4:3], i[10:0]};
				br = 1'b1;
			end
			default: begin
				uz = op[3] && op != 4'hb;
				ar = op[3] && op[2];
				case (op)
					4'h8: r = a | w;
					4'h9: r = a & w;
					4'ha: r = a ^ w;
					default: if (!op[3]) r = a;
				endcase
				if (op[3:2] == 2'h1) begin
					sp = (sp + 7) % 8;
					nfa = stk[sp];
					br = 1'b1;
				end
			end
		endcase
		if (ar && sb) begin
			c = a >= w;
			dcar = a[3:0] >= w[3:0];
			r = a - w;
		end else if (ar) begin
			dcar = ({1'b0, a[3:0]} + {1'b0, w[3:0]}) > 5'hf;
			{c, r} = {1'b0, a} + {1'b0, w};
		end
		if (uz) z = (r == 8'h0);
		if (i[13:12] == 2'h3 || (dst && !i[7])) w = r;
		if (dst && i[7]) wr = 1'b1;
		ewe = wr;
		if (wr) begin
			mf[f] = r;
			ea = f;
			ed = r;
			epc = (f == 7'h01) && prescaler_on_timer;
		end
	endtask

	// one instruction cycle; the write strobe stands only until the next edge
	task automatic cycle;
		logic br;
		logic [12:0] nfa;
		@(posedge ref_clk);
		#1;
		exec(mi, br, nfa);
		mi = br ? 14'h0000 : prog[fa[5:0]];
		fa = nfa;
		chk("fetch", 16'(prog_addr_q), 16'(fa));
		chk("work", 16'(working_q), 16'(w));
		chk("flags", 16'(flags_q), 16'({c, dcar, z}));
		chk("status", 16'({t_q, p_q, ie_q}), 16'({t_out, p_dn, ie}));
		chk("wstrobe", 16'({file_req_q.we, pclr_q}), 16'({ewe, ewe & epc}));
		if (ewe) chk("wdata", 16'({file_req_q.addr, file_req_q.wdata}), 16'({ea, ed}));
		if (file_req_q.we === 1'b1) fmem[file_req_q.addr] = file_req_q.wdata;
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic restart(input logic p);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		hl <= seed[4:0];
		prescaler_on_timer <= p;
		port_pins <= seed[12:5];
		for (int a = 0; a < 128; a++) begin
			fmem[a] = 8'(a * 37);
			mf[a] = 8'(a * 37);
		end
		for (int a = 0; a < 64; a++) rid_prog_mem_i.mem[a] = prog[a];
		fa = 13'h0;
		mi = 14'h0;
		w = 8'h0;
		{c, dcar, z, ie} = 4'h0;
		{t_out, p_dn} = 2'h3;
		sp = 0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask

	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		#400000;
		miscompares++;
		test_done;
	end

	initial begin
		rst_n = 1'b0;
		hl = 5'h0;
		prescaler_on_timer = 1'b0;
		wake_req = 1'b0;
		port_pins = 8'h0;
		{miscompares, cmp_count, wd_seen, wd_exp} = 128'h0;
		seed = 16'd19275;
		for (int run = 0; run < 2; run++) begin
			// a chain of calls first, so every stack slot holds a known address
			for (int a = 0; a < 64; a++) begin
				seed = lfsr_next(seed);
				prog[a] = (a < 8) ? (14'h2000 | 14'(a + 1)) : seed[13:0];
				if (prog[a] == 14'h0063) prog[a] = 14'h0000;
			end
			prog[20] = 14'h0064;
			prog[40] = 14'h0009;
			prog[30] = 14'h0008;
			restart(run[0]);
			repeat (600) cycle;
			chk("wdclr", 16'(wd_seen), 16'(wd_exp));
		end
		for (int a = 0; a < 64; a++) prog[a] = 14'h0000;
		// a decrement that reaches zero and skips, then standby
		prog[0] = 14'h3001;
		prog[1] = 14'h00a0;
		prog[2] = 14'h0ba0;
		prog[3] = 14'h3077;
		prog[4] = 14'h30a5;
		prog[5] = 14'h0063;
		prog[6] = 14'h303c;
		restart(1'b0);
		repeat (7) cycle;
		repeat (8) @(posedge ref_clk);
		#1;
		chk("standby", 16'({osc_stop_q, prog_addr_q}), 16'({1'b1, fa}));
		@(posedge ref_clk);
		wake_req <= 1'b1;
		for (int n = 0; n < 40 && working_q !== 8'h3c; n++) begin
			@(posedge ref_clk);
			#1;
		end
		chk("wake", 16'({osc_stop_q, working_q}), 16'h003c);
		test_done;
	end
endmodule
`default_nettype wire
